/* File: rtl/smbst_core.sv */
// SMBus master/slave engine with state-code register behind AHB-Lite
`default_nettype none

module smbst_core
  import smbst_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Open-drain bus pins
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe
);
  smbst_line_if ln ();

  smbst_line_sense u_sense (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .ln        (ln)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic        ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff, busy_ff;
  logic [7:0]  addr_ff, rate_ff, shift_ff, code_ff, tmr_ff;
  logic [3:0]  bit_ff;
  logic [11:0] hi_cnt_ff;
  logic        dir_ff, arb_ff, ack_ff, last_ff, nack_ff;
  logic        scl_oe_ff, sda_oe_ff;
  logic        a_we_ff;
  logic [7:0]  a_idx_ff;
  logic [31:0] rdata_ff;
  smbst_ms_t   ms_ff, nxt_ms;
  smbst_ph_t   ph_ff, nxt_ph;

  logic        tick, cnt_en, byte_done, berr, tmo, arb_adr, arb_dat;
  logic        slv_end, slv_sto, kill, ev_set, idle_ent;
  logic        a_ok, scl_w, sda_w, data_w, slv_ph;
  logic [7:0]  ev_code, rd_mux;
  logic [11:0] bft_lim;

  function automatic logic own_hit(input logic [7:0] b, input logic [7:0] a);
    own_hit = (b[7:1] == a[7:1]);
  endfunction

  function automatic logic gc_hit(input logic [7:0] b, input logic [7:0] a);
    gc_hit = (b == 8'h00) && a[0];
  endfunction

  function automatic logic wr_to(input logic we, input logic [7:0] i, input logic [7:0] r);
    wr_to = we && (i == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus events
  assign tick      = (tmr_ff == TMR_TOP);
  assign slv_ph    = (ph_ff == PH_SRX) || (ph_ff == PH_SGRX) || (ph_ff == PH_STX);
  assign byte_done = ln.scl_fall && (bit_ff == BIT_ACK) && (ph_ff != PH_NONE);
  assign berr      = (ln.start_det || ln.stop_det) && (ph_ff != PH_NONE) && (bit_ff != 4'h0);
  assign bft_lim   = 12'(BFT_MULT * (BFT_BASE - int'(rate_ff)));
  assign tmo       = fte_ff && busy_ff && ln.scl_s && (hi_cnt_ff >= bft_lim);
  // Our released bit read back low: another master wins
  assign arb_adr   = ln.scl_rise && (ph_ff == PH_MADDR) && (bit_ff != BIT_ACK)
                     && shift_ff[7] && !ln.sda_s;
  assign arb_dat   = ln.scl_rise && (ph_ff == PH_MTX) && (bit_ff != BIT_ACK)
                     && shift_ff[7] && !ln.sda_s;
  assign slv_end   = (ln.start_det || ln.stop_det) && (ms_ff == MS_IDLE)
                     && (bit_ff == 4'h0) && slv_ph;
  assign slv_sto   = sto_ff && (ms_ff == MS_IDLE) && (ph_ff != PH_NONE);
  assign kill      = !ens_ff || berr || tmo || arb_dat || ln.stop_det || slv_sto;
  assign idle_ent  = !ev_set && !si_ff && (ms_ff == MS_IDLE) && (ph_ff == PH_NONE);

  // Code of the state entered this cycle
  always_comb begin
    ev_set  = 1'b1;
    ev_code = code_ff;
    if (!ens_ff) begin
      ev_set = 1'b0;
    end else if (berr) begin
      ev_code = SC_BUS_ERR;
    end else if (tmo) begin
      ev_code = SC_SCL_TMO;
    end else if (arb_dat) begin
      ev_code = SC_ARB_LOST;
    end else if (byte_done) begin
      unique case (ph_ff)
        PH_MADDR: if (dir_ff) ev_code = ack_ff ? SC_MAR_ACK : SC_MAR_NACK;
                  else ev_code = ack_ff ? SC_MAW_ACK : SC_MAW_NACK;
        PH_MTX:   ev_code = ack_ff ? SC_MTD_ACK : SC_MTD_NACK;
        PH_MRX:   ev_code = ack_ff ? SC_MRD_ACK : SC_MRD_NACK;
        PH_SRX:   ev_code = ack_ff ? SC_SRD_ACK : SC_SRD_NACK;
        PH_SGRX:  ev_code = ack_ff ? SC_SGD_ACK : SC_SGD_NACK;
        PH_STX:   ev_code = !ack_ff ? SC_STD_NACK : (last_ff ? SC_STD_LAST : SC_STD_ACK);
        PH_SADDR: begin
          if (!ack_ff) ev_set = 1'b0;
          else if (gc_hit(shift_ff, addr_ff)) ev_code = arb_ff ? SC_SGC_A : SC_SGC;
          else if (!own_hit(shift_ff, addr_ff)) ev_set = 1'b0;
          else if (shift_ff[0]) ev_code = arb_ff ? SC_SOWN_RA : SC_SOWN_R;
          else ev_code = arb_ff ? SC_SOWN_WA : SC_SOWN_W;
        end
        default:  ev_set = 1'b0;
      endcase
    end else if (ms_ff == MS_START_B && tick) begin
      ev_code = (ph_ff == PH_NONE) ? SC_START : SC_RSTART;
    end else if (slv_end) begin
      ev_code = SC_SLV_END;
    end else begin
      ev_set = 1'b0;
    end
  end

  // Code register: changes only on state entry
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      code_ff <= SC_IDLE;
    end else if (i_ce) begin
      if (ev_set) code_ff <= ev_code;
      else if (idle_ent) code_ff <= SC_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {busy_ff, ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff} <= CTRL_RST;
    end else if (i_ce) begin
      if (wr_to(a_we_ff, a_idx_ff, IDX_CTRL)) begin
        ens_ff <= i_hwdata[CB_ENS];
        sta_ff <= i_hwdata[CB_STA];
        sto_ff <= i_hwdata[CB_STO];
        aa_ff  <= i_hwdata[CB_AA];
        fte_ff <= i_hwdata[CB_FTE];
        toe_ff <= i_hwdata[CB_TOE];
        if (!i_hwdata[CB_SI]) si_ff <= 1'b0;
      end
      // Hardware set wins over a clear in the same cycle
      if (ev_set) si_ff <= 1'b1;
      if (ln.stop_det || slv_sto || (sto_ff && ms_ff == MS_IDLE && ph_ff == PH_NONE)) sto_ff <= 1'b0;
      if (ln.start_det) busy_ff <= 1'b1;
      else if (ln.stop_det || tmo || !ens_ff) busy_ff <= 1'b0;
    end
  end

  // Slave address and rate preset
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_ff <= ADDR_RST;
      rate_ff <= RATE_RST;
    end else if (i_ce) begin
      if (wr_to(a_we_ff, a_idx_ff, IDX_ADDR)) addr_ff <= i_hwdata[7:0];
      if (wr_to(a_we_ff, a_idx_ff, IDX_RATE)) rate_ff <= i_hwdata[7:0];
    end
  end

  // SCL high time for the free-bus timeout
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) hi_cnt_ff <= 12'h000;
    else if (i_ce) hi_cnt_ff <= (ln.scl_s && busy_ff && !tmo) ? hi_cnt_ff + 12'h001 : 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer and rate timer
  always_comb begin
    nxt_ms = ms_ff;
    unique case (ms_ff)
      MS_IDLE:    if (ens_ff && sta_ff && !sto_ff && !busy_ff) nxt_ms = MS_START_A;
      MS_START_A: if (busy_ff) nxt_ms = MS_IDLE;
                  else if (tick) nxt_ms = MS_START_B;
      MS_START_B: if (tick) nxt_ms = MS_LOW;
      MS_LOW:     if (si_ff) nxt_ms = MS_HOLD;
                  else if (tick) nxt_ms = MS_HIGH;
      MS_HIGH:    if (tick) nxt_ms = MS_LOW;
      MS_HOLD:    if (!si_ff) nxt_ms = sto_ff ? MS_STOP_A : (sta_ff ? MS_RS_A : MS_LOW);
      MS_RS_A:    if (tick) nxt_ms = MS_RS_B;
      MS_RS_B:    if (tick) nxt_ms = MS_START_B;
      MS_STOP_A:  if (tick) nxt_ms = MS_STOP_B;
      MS_STOP_B:  if (tick) nxt_ms = MS_STOP_C;
      MS_STOP_C:  if (tick) nxt_ms = sta_ff ? MS_START_A : MS_IDLE;
    endcase
    if (!ens_ff || berr || tmo || arb_dat || arb_adr) nxt_ms = MS_IDLE;
  end

  // SCL-high phases MS_HIGH, MS_RS_B and MS_STOP_B wait for the wire: slower masters stretch them
  assign cnt_en = (ms_ff != MS_IDLE) && (ms_ff != MS_HOLD) && !(si_ff && ms_ff == MS_LOW)
                  && (ln.scl_s || !(ms_ff == MS_HIGH || ms_ff == MS_RS_B || ms_ff == MS_STOP_B));

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ms_ff  <= MS_IDLE;
      tmr_ff <= RATE_RST;
    end else if (i_ce) begin
      ms_ff <= nxt_ms;
      if (nxt_ms != ms_ff) tmr_ff <= rate_ff;
      else if (cnt_en) tmr_ff <= tmr_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always_comb begin
    nxt_ph = ph_ff;
    unique case (ph_ff)
      PH_MADDR: if (ack_ff) nxt_ph = dir_ff ? PH_MRX : PH_MTX;
      PH_SADDR: begin
        if (!ack_ff) nxt_ph = PH_NONE;
        else if (gc_hit(shift_ff, addr_ff)) nxt_ph = PH_SGRX;
        else if (!own_hit(shift_ff, addr_ff)) nxt_ph = PH_NONE;
        else nxt_ph = shift_ff[0] ? PH_STX : PH_SRX;
      end
      default:  nxt_ph = ph_ff;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ph_ff    <= PH_NONE;
      bit_ff   <= 4'h0;
      shift_ff <= DATA_RST;
      {dir_ff, arb_ff, ack_ff, last_ff, nack_ff} <= 5'h00;
    end else if (i_ce) begin
      if (wr_to(a_we_ff, a_idx_ff, IDX_DATA)) shift_ff <= i_hwdata[7:0];
      // A START seen by an idle engine opens a slave address byte instead
      if (kill && !(ln.start_det && ms_ff == MS_IDLE && ens_ff)) begin
        ph_ff  <= PH_NONE;
        bit_ff <= 4'h0;
      end else if (ms_ff == MS_START_B && tick) begin
        // START's own SCL fall wraps the count to zero, not a bit
        ph_ff  <= PH_MADDR;
        bit_ff <= 4'hf;
        arb_ff <= 1'b0;
      end else if (ln.start_det && ms_ff == MS_IDLE && ens_ff) begin
        ph_ff   <= PH_SADDR;
        bit_ff  <= 4'hf;
        arb_ff  <= 1'b0;
        nack_ff <= 1'b0;
      end else if (ph_ff != PH_NONE) begin
        if (ln.scl_rise && bit_ff == BIT_ACK) begin
          ack_ff <= !ln.sda_s;
        end else if (ln.scl_rise) begin
          // Received bits land in the data register, lost address arbitration included
          shift_ff <= {shift_ff[6:0], ln.sda_s};
          if (bit_ff == 4'h0 && ph_ff == PH_MADDR) dir_ff <= shift_ff[0];
          if (bit_ff == 4'h0 && ph_ff == PH_STX) last_ff <= !aa_ff;
          if (arb_adr) begin
            ph_ff  <= PH_SADDR;
            arb_ff <= 1'b1;
          end
        end
        if (byte_done) begin
          bit_ff <= 4'h0;
          ph_ff  <= nxt_ph;
          if (ph_ff == PH_STX && !ack_ff) nack_ff <= 1'b1;
        end else if (ln.scl_fall) begin
          bit_ff <= bit_ff + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_comb begin
    if (bit_ff != BIT_ACK) begin
      data_w = !shift_ff[7] && ((ms_ff != MS_IDLE && (ph_ff == PH_MADDR || ph_ff == PH_MTX))
               || (ms_ff == MS_IDLE && ph_ff == PH_STX && !nack_ff));
    end else begin
      data_w = aa_ff && ((ph_ff == PH_MRX && ms_ff != MS_IDLE) || ph_ff == PH_SRX || ph_ff == PH_SGRX
               || (ph_ff == PH_SADDR && (own_hit(shift_ff, addr_ff) || gc_hit(shift_ff, addr_ff))));
    end
    // Data only moves while SCL reads low
    sda_w = ln.scl_s ? sda_oe_ff : data_w;
    scl_w = si_ff && ms_ff == MS_IDLE && slv_ph && bit_ff == 4'h0 && ack_ff && !nack_ff;
    unique case (ms_ff)
      MS_START_A, MS_RS_A, MS_RS_B, MS_STOP_C: sda_w = 1'b0;
      MS_START_B, MS_STOP_B:                   sda_w = 1'b1;
      MS_STOP_A: begin
        sda_w = 1'b1;
        scl_w = 1'b1;
      end
      MS_LOW, MS_HOLD:                         scl_w = 1'b1;
      MS_IDLE, MS_HIGH:                        scl_w = scl_w;
    endcase
    if (!ens_ff) begin
      sda_w = 1'b0;
      scl_w = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (i_ce) begin
      scl_oe_ff <= scl_w;
      sda_oe_ff <= sda_w;
    end
  end

  assign o_scl    = 1'b0;
  assign o_sda    = 1'b0;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_oe = sda_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign a_ok = i_hsel && i_htrans[1] && i_hready && (i_haddr[31:10] == 22'h000000);

  always_comb begin
    unique case (i_haddr[9:2])
      IDX_CTRL: rd_mux = {busy_ff, ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff};
      IDX_CODE: rd_mux = code_ff;
      IDX_DATA: rd_mux = shift_ff;
      IDX_ADDR: rd_mux = addr_ff;
      IDX_RATE: rd_mux = rate_ff;
      default:  rd_mux = 8'h00;
    endcase
  end

  // Writes to the code register are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      a_we_ff  <= 1'b0;
      a_idx_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else if (i_ce) begin
      a_we_ff  <= a_ok && i_hwrite && (i_haddr[9:2] != IDX_CODE);
      a_idx_ff <= i_haddr[9:2];
      rdata_ff <= (a_ok && !i_hwrite) ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  assign o_hrdata    = rdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_hold_sto;
    i_ce && ms_ff == MS_HOLD && !si_ff && sto_ff && sta_ff;
  endsequence

  sequence s_stop_walk;
    ms_ff == MS_STOP_A;
  endsequence

  a_low_bits_zero: assert property (
    si_ff |-> code_ff[2:0] == 3'h0) else $error("valid code not multiple of eight");
  a_idle_no_flag: assert property (
    $rose(si_ff) |-> code_ff != SC_IDLE) else $error("idle code raised flag");
  a_entry_sets_flag: assert property (
    i_ce && ev_set |=> si_ff && code_ff == $past(ev_code)) else $error("state entry lost");
  a_code_holds: assert property (
    i_ce && !ev_set && !idle_ent |=> $stable(code_ff)) else $error("code changed without entry");
  a_start_code: assert property (
    i_ce && ms_ff == MS_START_B && tick && ph_ff == PH_NONE && !berr && !tmo
    |=> code_ff == SC_START && si_ff) else $error("start code missing");
  a_addr_write_ack: assert property (
    i_ce && byte_done && ph_ff == PH_MADDR && !dir_ff && ack_ff && ens_ff && !tmo
    |=> code_ff == SC_MAW_ACK && ph_ff == PH_MTX) else $error("address ack code wrong");
  a_data_ack: assert property (
    i_ce && byte_done && ph_ff == PH_MTX && ack_ff && ens_ff && !tmo
    |=> code_ff == SC_MTD_ACK) else $error("data ack code wrong");
  a_arb_lost: assert property (
    i_ce && arb_dat && ens_ff && !tmo |=> code_ff == SC_ARB_LOST ##1 ms_ff == MS_IDLE)
    else $error("arbitration loss not reported");
  a_bus_error: assert property (
    i_ce && berr && ens_ff |=> code_ff == SC_BUS_ERR
    && ph_ff == ($past(ln.start_det && ms_ff == MS_IDLE) ? PH_SADDR : PH_NONE)) else $error("bus error missed");
  a_stop_first: assert property (
    s_hold_sto |=> s_stop_walk) else $error("stop not sent before start");
  a_stop_clears: assert property (
    i_ce && ln.stop_det |=> !sto_ff) else $error("stop request not cleared");
endmodule

`default_nettype wire

/* File: rtl/smbst_line_if.sv */
// Synchronised SCL/SDA levels and bus conditions between sensing and core
`default_nettype none

interface smbst_line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sense (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
  modport core  (input  scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
endinterface

`default_nettype wire

/* File: rtl/smbst_line_sense.sv */
// Pin synchroniser and SCL edge / START / STOP detector
`default_nettype none

module smbst_line_sense
  import smbst_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  // Pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Core side
  smbst_line_if.sense ln
);
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_prev_ff;
  logic       sda_prev_ff;

  // First stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else if (i_ce) begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  assign ln.scl_s     = scl_sync_ff[1];
  assign ln.sda_s     = sda_sync_ff[1];
  assign ln.scl_rise  = i_ce & scl_sync_ff[1] & ~scl_prev_ff;
  assign ln.scl_fall  = i_ce & ~scl_sync_ff[1] & scl_prev_ff;
  assign ln.start_det = i_ce & scl_sync_ff[1] & scl_prev_ff & ~sda_sync_ff[1] & sda_prev_ff;
  assign ln.stop_det  = i_ce & scl_sync_ff[1] & scl_prev_ff & sda_sync_ff[1] & ~sda_prev_ff;
endmodule

`default_nettype wire

/* File: rtl/smbst_pkg.sv */
// Constants, state codes and register map of the SMBus state-code block
// Function
// - Five-bit code names each of 28 states
// - Code is valid only while event flag set
// - Low three code bits read zero when valid
// - Idle code 0xf8 never raises event flag
// - START gives 0x08, repeated START 0x10
// - Address plus write: ACK 0x18, NACK 0x20
// - Master data sent: ACK 0x28, NACK 0x30
// - Address plus read: ACK 0x40, NACK 0x48
// - Master byte received: ACK 0x50, NACK 0x58
// - Own write address 0x60, general call 0x70
// - Lost address arbitration, addressed: 0x68/0x78/0xb0
// - Lost arbitration in a sent data byte: 0x38; lost address, not addressed: no code
// - Slave data received: ACK 0x80, NACK 0x88
// - General call data: ACK 0x90, NACK 0x98
// - Addressed slave sees STOP/repeated START: 0xa0
// - Slave transmit: 0xa8, then ACK 0xb8, NACK 0xc0
// - Last byte yet ACKed by master: 0xc8
// - SCL high timer expiry gives 0xd0
// - Illegal START or STOP gives 0x00
// - Non-idle state entry sets sticky event flag
// - Stop then start; received STOP clears request
`default_nettype none

package smbst_pkg;
  // State codes
  localparam logic [7:0] SC_BUS_ERR   = 8'h00;
  localparam logic [7:0] SC_START     = 8'h08;
  localparam logic [7:0] SC_RSTART    = 8'h10;
  localparam logic [7:0] SC_MAW_ACK   = 8'h18;
  localparam logic [7:0] SC_MAW_NACK  = 8'h20;
  localparam logic [7:0] SC_MTD_ACK   = 8'h28;
  localparam logic [7:0] SC_MTD_NACK  = 8'h30;
  localparam logic [7:0] SC_ARB_LOST  = 8'h38;
  localparam logic [7:0] SC_MAR_ACK   = 8'h40;
  localparam logic [7:0] SC_MAR_NACK  = 8'h48;
  localparam logic [7:0] SC_MRD_ACK   = 8'h50;
  localparam logic [7:0] SC_MRD_NACK  = 8'h58;
  localparam logic [7:0] SC_SOWN_W    = 8'h60;
  localparam logic [7:0] SC_SOWN_WA   = 8'h68;
  localparam logic [7:0] SC_SGC       = 8'h70;
  localparam logic [7:0] SC_SGC_A     = 8'h78;
  localparam logic [7:0] SC_SRD_ACK   = 8'h80;
  localparam logic [7:0] SC_SRD_NACK  = 8'h88;
  localparam logic [7:0] SC_SGD_ACK   = 8'h90;
  localparam logic [7:0] SC_SGD_NACK  = 8'h98;
  localparam logic [7:0] SC_SLV_END   = 8'ha0;
  localparam logic [7:0] SC_SOWN_R    = 8'ha8;
  localparam logic [7:0] SC_SOWN_RA   = 8'hb0;
  localparam logic [7:0] SC_STD_ACK   = 8'hb8;
  localparam logic [7:0] SC_STD_NACK  = 8'hc0;
  localparam logic [7:0] SC_STD_LAST  = 8'hc8;
  localparam logic [7:0] SC_SCL_TMO   = 8'hd0;
  localparam logic [7:0] SC_IDLE      = 8'hf8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL     = 8'hc0;
  localparam logic [7:0] IDX_CODE     = 8'hc1;
  localparam logic [7:0] IDX_DATA     = 8'hc2;
  localparam logic [7:0] IDX_ADDR     = 8'hc3;
  localparam logic [7:0] IDX_RATE     = 8'hcf;

  // Control register bit positions
  localparam int CB_BUSY = 7;
  localparam int CB_ENS  = 6;
  localparam int CB_STA  = 5;
  localparam int CB_STO  = 4;
  localparam int CB_SI   = 3;
  localparam int CB_AA   = 2;
  localparam int CB_FTE  = 1;
  localparam int CB_TOE  = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;

  // Counts
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [7:0] TMR_TOP  = 8'hff;
  localparam int         BFT_MULT = 10;
  localparam int         BFT_BASE = 257;

  typedef enum logic [3:0] {
    MS_IDLE, MS_START_A, MS_START_B, MS_LOW, MS_HIGH, MS_HOLD,
    MS_RS_A, MS_RS_B, MS_STOP_A, MS_STOP_B, MS_STOP_C
  } smbst_ms_t;

  typedef enum logic [2:0] {
    PH_NONE, PH_MADDR, PH_MTX, PH_MRX, PH_SADDR, PH_SRX, PH_SGRX, PH_STX
  } smbst_ph_t;
endpackage

`default_nettype wire

/* File: verification/smbst_slave_model.sv */
// Behavioural SMBus slave that answers the block's master traffic
`default_nettype none

module smbst_slave_model #(
  parameter logic [6:0] SLV = 7'h2a
) (
  // Bus wires
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain drive
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bitn;
  logic       first;
  logic [7:0] sh;
  initial begin
    o_sda_oe = 1'b0;
    bitn     = 0;
    first    = 1'b1;
    sh       = 8'h00;
  end
  // START re-arms; the START's own SCL fall is not a bit
  always @(negedge i_sda) begin
    if (i_scl) begin
      bitn     = -1;
      first    = 1'b1;
      o_sda_oe = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], i_sda};
  end
  // Ack only its own address, every data byte after it
  always @(negedge i_scl) begin
    if (bitn == 8) begin
      bitn     = 0;
      first    = 1'b0;
      o_sda_oe = 1'b0;
    end else begin
      bitn++;
      if (bitn == 8) o_sda_oe = first ? (sh[7:1] == SLV) : 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb_smbus_status_state_codes.sv */
// Self-checking bench: master transfers against a slave model, state codes compared
`default_nettype none

module tb_smbus_status_state_codes;
  import smbst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SLV = 7'h2a;
  logic        clk, srst, hsel, hwrite, hready, resp, d_scl_oe, d_sda_oe, s_sda_oe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire logic   scl = !d_scl_oe;
  wire logic   sda = !(d_sda_oe | s_sda_oe);
  int          err_count, checked;
  logic [7:0]  rnd, bad;

  smbst_core smbst_core_inst (.i_ref_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(resp), .i_scl(scl), .o_scl(), .o_scl_oe(d_scl_oe),
    .i_sda(sda), .o_sda(), .o_sda_oe(d_sda_oe));
  smbst_slave_model #(.SLV(SLV)) smbst_slave_model_inst (.i_scl(scl), .i_sda(sda), .o_sda_oe(s_sda_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Single AHB-Lite word transfer; read data taken at the data phase's edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      ahb(1'b0, 32'h300, 32'h0, rd);
      n++;
    end while (rd[3] !== 1'b1 && n < 500);
    check({31'h0, rd[3]}, 32'h1);
  endtask

  // Load data, write control, then compare the new code with the model's
  task automatic step(input logic [7:0] dat, input logic [7:0] ctl, input logic [7:0] exp);
    ahb(1'b1, 32'h308, {24'h0, dat}, rd);
    ahb(1'b1, 32'h300, {24'h0, ctl}, rd);
    wait_flag();
    ahb(1'b0, 32'h304, 32'h0, rd);
    check(rd, {24'h0, exp});
  endtask

  // Model: slave acks only its own address, then every data byte
  function automatic logic [7:0] addr_w_code(input logic [7:0] a);
    return (a[7:1] == SLV) ? SC_MAW_ACK : SC_MAW_NACK;
  endfunction

  initial begin
    int n;
    err_count = 0;
    checked   = 0;
    srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rnd = 8'($urandom(88));
    rnd = 8'($urandom);
    bad = {SLV ^ 7'(1 + $urandom % 127), 1'b0};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    ahb(1'b0, 32'h304, 32'h0, rd);
    check(rd, {24'h0, SC_IDLE});
    ahb(1'b0, 32'h300, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b1, 32'h3fc, {24'h0, rnd}, rd);
    ahb(1'b0, 32'h3fc, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, resp}, 32'h0);
    ahb(1'b1, 32'h33c, 32'hf0, rd);
    step(8'h00, 8'h60, SC_START);
    step({SLV, 1'b0}, 8'h40, addr_w_code({SLV, 1'b0}));
    step(rnd, 8'h40, SC_MTD_ACK);
    step(8'h00, 8'h70, SC_START);
    ahb(1'b0, 32'h300, 32'h0, rd);
    check({31'h0, rd[4]}, 32'h0);
    step(bad, 8'h40, addr_w_code(bad));
    ahb(1'b1, 32'h300, 32'h50, rd);
    n = 0;
    do begin
      ahb(1'b0, 32'h304, 32'h0, rd);
      n++;
    end while (rd !== {24'h0, SC_IDLE} && n < 500);
    check(rd, {24'h0, SC_IDLE});
    ahb(1'b0, 32'h300, 32'h0, rd);
    check({31'h0, rd[3]}, 32'h0);
    report_and_stop();
  end

  // Watchdog far beyond the twelve hundred or so cycles the sequence needs
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
